/* dummy_end_marker_none.sv */
`timescale 1ns/1ps

/* ldm_consts.svh */
`ifndef LDM_CONSTS_SVH
`define LDM_CONSTS_SVH
// ==================================================
// address map
`define LDM_GLOBAL_BIT    9
`define LDM_CH_MSB        8
`define LDM_CH_LSB        5
`define LDM_REG_DEFECT    3'h0
`define LDM_REG_LOSS_CFG  3'h1
`define LDM_REG_RX_CFG    3'h2
`define LDM_REG_STATUS_REG_ZERO     3'h3
`define LDM_REG_IRQS0     3'h4
`define LDM_REG_IRQM0     3'h5
`define LDM_REG_IRQS2     3'h6
`define LDM_REG_IRQM2     3'h7
`define LDM_GREG_MODE     3'h0
`define LDM_GREG_CLKGEN   3'h1
`define LDM_GREG_EDGE     3'h2
// ==================================================
// field positions
`define LDM_BIT_FCC       7
`define LDM_BIT_INS       6
`define LDM_BIT_CRIT      7
`define LDM_THR_LSB       4
`define LDM_BIT_HOLD      7
`define LDM_BIT_TXNRZ     2
`define LDM_BIT_LOSS      0
`define LDM_BIT_RXZ       2
`define LDM_BIT_TXZ       3
`define LDM_BIT_E1        0
`define LDM_BIT_CLKEN     3
`define LDM_BIT_CLKSEL    2
`define LDM_BIT_EDGE      1
// ==================================================
// zero-run thresholds and loss windows
`define LDM_ZMAX          7'h7F
`define LDM_Z_AMI         7'h0F
`define LDM_Z_AMI_FCC_T1  7'h50
`define LDM_Z_B8ZS        7'h07
`define LDM_Z_HDB3        7'h03
`define LDM_N_T1_SHORT    12'h0AF
`define LDM_N_T1_LONG     12'h608
`define LDM_N_E1_SHORT    12'h020
`define LDM_N_E1_LONG     12'h800
`define LDM_LOW_MAX       12'hFFF
`define LDM_M_T1          8'hAF
`define LDM_M_E1          8'h20
`define LDM_ZLIM_T1       7'h64
`define LDM_ZLIM_E1       7'h10
`define LDM_DENSITY_DIV   11'h008
`define LDM_AMP_STEP_MV   50
`define LDM_P_MARGIN_MV   250
`define LDM_Q_BASE        8'h02
`define LDM_Q_STEP        8'h02
// ==================================================
// derived rate clock accumulator steps (2^24 * rate / 100 MHz)
`define LDM_INC_T1        24'h03F3E0
`define LDM_INC_E1        24'h053E2D
`define LDM_IND_HALF      8'h19
`define LDM_SLOT_LAST     5'h10
`endif

/* ldm_line_defect_monitor.sv */
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "ldm_consts.svh"
// Function
// - violations are inserted only into the transmit stream, never the receive one
// - writing one requests one violation on next transmit mark; bit self-clears after
// - zero runs are watched separately on receive and transmit of every channel
// - standard select bit picks ANSI (zero) or FCC (one) zero-run limits
// - ANSI: first code flags a run of more than 15 zeros
// - FCC: first code flags above 80 zeros in T1/J1, above 15 in E1
// - second and third codes flag above 7 and above 3 zeros
// - single-rail NRZ transmit input uses AMI limits for transmit zero runs
// - receive zero run sets receive zero-run status; interrupt unless masked
// - transmit zero run sets transmit zero-run status; interrupt unless masked
// - loss declared after N intervals with amplitude below selected threshold Q
// - loss clears after M intervals from a mark above Q plus 250 mVpp, density 12.5%
// - T1/J1: N is 175 or 1544, M is 175, zero runs below 100
// - E1: N is 32 or 2048, M is 32, zero runs below 16
// - loss state shown; rising or any edge sets loss status, interrupt unless masked
// - frame marker high one indication cycle, 16 channel states, frame of 17 cycles
// - indication pins float while indication clock is disabled
// - during loss receive data forced low except in sliced format
// - during loss receive clock is held high or derived clock per hold bit
// - derived clock from master clock at 1.544 or 2.048 MHz by mode
// - active override path keeps its own data and clock, hold bit ignored
module ldm_line_defect_monitor import ldm_pkg::*; #(
	parameter logic [7:0] IND_HALF = `LDM_IND_HALF
) (
	// clock and reset
	input  wire logic                             clk_i,
	input  wire logic                             rst_b_i,
	// register bus
	input  wire ldm_ahb_req_type                  ahb_i,
	output logic                                  hreadyout_o,
	output logic                                  hresp_o,
	output logic [31:0]                           hrdata_o,
	// bit timing
	input  wire logic                             bit_en_i,
	// receive line side
	input  wire logic [LDM_NUM_CH-1:0]            rx_mark_i,
	input  wire logic [LDM_NUM_CH-1:0][7:0]       rx_amp_i,
	input  wire logic [LDM_NUM_CH-1:0]            rx_pos_i,
	input  wire logic [LDM_NUM_CH-1:0]            rx_neg_i,
	input  wire logic [LDM_NUM_CH-1:0]            rx_clk_i,
	input  wire logic [LDM_NUM_CH-1:0]            rx_override_i,
	// transmit stream
	input  wire logic [LDM_NUM_CH-1:0]            tx_pos_i,
	input  wire logic [LDM_NUM_CH-1:0]            tx_neg_i,
	output logic [LDM_NUM_CH-1:0]                 tx_pos_o,
	output logic [LDM_NUM_CH-1:0]                 tx_neg_o,
	// receive system side
	output logic [LDM_NUM_CH-1:0]                 rx_positive_data_out_o,
	output logic [LDM_NUM_CH-1:0]                 rx_negative_data_out_o,
	output logic [LDM_NUM_CH-1:0]                 rx_clock_out_o,
	// loss indication pins
	output logic                                  indication_clock_out_o,
	output logic                                  loss_frame_marker_o,
	output logic                                  loss_frame_marker_oe_o,
	output logic                                  line_signal_loss_o,
	output logic                                  line_signal_loss_oe_o,
	// clock and interrupt
	output logic                                  derived_rate_clock_o,
	output logic                                  int_b_o
);
	// ==================================================
	// helpers
	function automatic logic [6:0] zthr(ldm_code_type c, logic fcc, logic e1);
		unique case (c)
			LDM_AMI:  zthr = (fcc && !e1) ? `LDM_Z_AMI_FCC_T1 : `LDM_Z_AMI;
			LDM_B8ZS: zthr = `LDM_Z_B8ZS;
			LDM_HDB3: zthr = `LDM_Z_HDB3;
			default:  zthr = `LDM_Z_AMI;
		endcase
	endfunction : zthr

	function automatic logic [11:0] nlim(logic e1, logic crit);
		if (e1)
			nlim = crit ? `LDM_N_E1_LONG : `LDM_N_E1_SHORT;
		else
			nlim = crit ? `LDM_N_T1_LONG : `LDM_N_T1_SHORT;
	endfunction : nlim

	localparam logic [7:0] P_OFS = 8'(`LDM_P_MARGIN_MV / `LDM_AMP_STEP_MV);

	ldm_state_type         r;
	ldm_state_type         next_r;
	logic [LDM_NUM_CH-1:0] rxz_set;
	logic [LDM_NUM_CH-1:0] txz_set;
	logic [LDM_NUM_CH-1:0] lis_set;
	logic [LDM_NUM_CH-1:0] irq_vec;
	logic [7:0]            q_lvl;
	logic [7:0]            p_lvl;
	logic [7:0]            m_lim;
	logic [6:0]            z_lim;
	logic [6:0]            tx_thr;
	logic                  tx_mark;
	logic                  force_rx;
	logic [3:0]            wch;
	logic [31:0]           rd;
	logic [31:0]           wd;

	// ==================================================
	// next state
	always_comb begin
		next_r  = r;
		rxz_set = '0;
		txz_set = '0;
		lis_set = '0;
		q_lvl   = '0;
		p_lvl   = '0;
		tx_thr  = '0;
		tx_mark = 1'b0;
		force_rx = 1'b0;
		wd      = ahb_i.hwdata;
		wch     = r.addr[`LDM_CH_MSB:`LDM_CH_LSB];
		m_lim   = r.mode_e1 ? `LDM_M_E1 : `LDM_M_T1;
		z_lim   = r.mode_e1 ? `LDM_ZLIM_E1 : `LDM_ZLIM_T1;

		// free-running phase accumulator; its top bit is the derived rate clock
		next_r.acc = r.acc + (r.mode_e1 ? `LDM_INC_E1 : `LDM_INC_T1);

		for (int i = 0; i < LDM_NUM_CH; i++) begin
			// receive outputs: registered every cycle
			force_rx = r.ch[i].loss && !rx_override_i[i];
			next_r.ch[i].rx_pos = (force_rx && r.ch[i].fmt != LDM_RX_SLICED) ? 1'b0 : rx_pos_i[i];
			next_r.ch[i].rx_neg = (force_rx && r.ch[i].fmt != LDM_RX_SLICED) ? 1'b0 : rx_neg_i[i];
			if (force_rx)
				next_r.ch[i].rx_clk = r.ch[i].hold ? 1'b1 : r.acc[23];
			else
				next_r.ch[i].rx_clk = rx_clk_i[i];

			// transmit is taken once per interval so a violation stands the whole bit; receive has no insertion path
			if (bit_en_i) begin
				next_r.ch[i].tx_pos = tx_pos_i[i];
				next_r.ch[i].tx_neg = tx_neg_i[i];
				tx_mark = tx_pos_i[i] | tx_neg_i[i];
				// a violation repeats the polarity of the previous mark
				if (tx_mark && r.ch[i].ins) begin
					next_r.ch[i].tx_pos = r.ch[i].last_pol;
					next_r.ch[i].tx_neg = !r.ch[i].last_pol;
					next_r.ch[i].ins    = 1'b0;
				end else if (tx_mark) begin
					next_r.ch[i].last_pol = tx_pos_i[i];
				end

				// receive zero run
				if (rx_mark_i[i])
					next_r.ch[i].rx_zero = '0;
				else if (r.ch[i].rx_zero != `LDM_ZMAX)
					next_r.ch[i].rx_zero = r.ch[i].rx_zero + 7'h01;
				if (!rx_mark_i[i] && r.ch[i].rx_zero == zthr(r.ch[i].code, r.ch[i].fcc, r.mode_e1))
					rxz_set[i] = 1'b1;

				// transmit zero run; single-rail NRZ input falls back to AMI limits
				tx_thr = zthr(r.ch[i].tx_nrz ? LDM_AMI : r.ch[i].code, r.ch[i].fcc, r.mode_e1);
				if (tx_mark)
					next_r.ch[i].tx_zero = '0;
				else if (r.ch[i].tx_zero != `LDM_ZMAX)
					next_r.ch[i].tx_zero = r.ch[i].tx_zero + 7'h01;
				if (!tx_mark && r.ch[i].tx_zero == tx_thr)
					txz_set[i] = 1'b1;

				// line loss
				q_lvl = `LDM_Q_BASE + 8'({5'h00, r.ch[i].thr} * `LDM_Q_STEP);
				p_lvl = q_lvl + P_OFS;
				if (!r.ch[i].loss) begin
					if (rx_amp_i[i] < q_lvl) begin
						if (r.ch[i].low_cnt != `LDM_LOW_MAX)
							next_r.ch[i].low_cnt = r.ch[i].low_cnt + 12'h001;
						if (r.ch[i].low_cnt + 12'h001 >= nlim(r.mode_e1, r.ch[i].crit)) begin
							next_r.ch[i].loss    = 1'b1;
							next_r.ch[i].win_act = 1'b0;
						end
					end else begin
						next_r.ch[i].low_cnt = '0;
					end
				end else if (!r.ch[i].win_act) begin
					// a clearing window may only open on a strong mark
					if (rx_mark_i[i] && rx_amp_i[i] > p_lvl) begin
						next_r.ch[i].win_act   = 1'b1;
						next_r.ch[i].win_cnt   = 8'h01;
						next_r.ch[i].win_marks = 8'h01;
						next_r.ch[i].win_zero  = '0;
					end
				end else if (rx_mark_i[i] && rx_amp_i[i] <= p_lvl) begin
					next_r.ch[i].win_act = 1'b0;
				end else begin
					next_r.ch[i].win_cnt   = r.ch[i].win_cnt + 8'h01;
					next_r.ch[i].win_marks = r.ch[i].win_marks + {7'h00, rx_mark_i[i]};
					next_r.ch[i].win_zero  = rx_mark_i[i] ? 7'h00 : r.ch[i].win_zero + 7'h01;
					if (!rx_mark_i[i] && r.ch[i].win_zero + 7'h01 >= z_lim) begin
						next_r.ch[i].win_act = 1'b0;
					end else if (r.ch[i].win_cnt + 8'h01 == m_lim) begin
						next_r.ch[i].win_act = 1'b0;
						if ({3'h0, next_r.ch[i].win_marks} * `LDM_DENSITY_DIV >= {3'h0, m_lim}) begin
							next_r.ch[i].loss    = 1'b0;
							next_r.ch[i].low_cnt = '0;
						end
					end
				end
			end
			if (next_r.ch[i].loss != r.ch[i].loss && (next_r.ch[i].loss || r.edge_any))
				lis_set[i] = 1'b1;
		end

		// indication pins: divider makes the indication clock, pins move on its rise
		if (!(r.clk_en && r.clk_sel)) begin
			next_r.ind_div = '0;
			next_r.ind_clk = 1'b0;
			next_r.slot    = '0;
			next_r.marker  = 1'b0;
			next_r.sdata   = 1'b0;
			next_r.pins_oe = 1'b0;
		end else begin
			next_r.pins_oe = 1'b1;
			if (r.ind_div == IND_HALF - 8'h01) begin
				next_r.ind_div = '0;
				next_r.ind_clk = !r.ind_clk;
				if (!r.ind_clk) begin
					next_r.marker = (r.slot == 5'h00);
					next_r.sdata  = r.slot[4] ? 1'b0 : r.ch[r.slot[3:0]].loss;
					next_r.slot   = (r.slot == `LDM_SLOT_LAST) ? 5'h00 : r.slot + 5'h01;
				end
			end else begin
				next_r.ind_div = r.ind_div + 8'h01;
			end
		end

		// bus data phase write; after the hardware self-clear so a new request survives
		if (r.wr_act) begin
			if (r.addr[`LDM_GLOBAL_BIT]) begin
				unique case (r.addr[4:2])
					`LDM_GREG_MODE:   next_r.mode_e1 = wd[`LDM_BIT_E1];
					`LDM_GREG_CLKGEN: begin
						next_r.clk_en  = wd[`LDM_BIT_CLKEN];
						next_r.clk_sel = wd[`LDM_BIT_CLKSEL];
					end
					`LDM_GREG_EDGE:   next_r.edge_any = wd[`LDM_BIT_EDGE];
					default:          ;
				endcase
			end else begin
				unique case (r.addr[4:2])
					`LDM_REG_DEFECT: begin
						next_r.ch[wch].fcc  = wd[`LDM_BIT_FCC];
						next_r.ch[wch].ins  = wd[`LDM_BIT_INS] | next_r.ch[wch].ins;
						next_r.ch[wch].code = ldm_code_type'(wd[1:0]);
					end
					`LDM_REG_LOSS_CFG: begin
						next_r.ch[wch].crit = wd[`LDM_BIT_CRIT];
						next_r.ch[wch].thr  = wd[`LDM_THR_LSB +: 3];
					end
					`LDM_REG_RX_CFG: begin
						next_r.ch[wch].hold   = wd[`LDM_BIT_HOLD];
						next_r.ch[wch].tx_nrz = wd[`LDM_BIT_TXNRZ];
						next_r.ch[wch].fmt    = ldm_rx_fmt_type'(wd[1:0]);
					end
					`LDM_REG_IRQS0: next_r.ch[wch].lis = r.ch[wch].lis & !wd[`LDM_BIT_LOSS];
					`LDM_REG_IRQM0: next_r.ch[wch].lim = wd[`LDM_BIT_LOSS];
					`LDM_REG_IRQS2: begin
						next_r.ch[wch].rxz_is = r.ch[wch].rxz_is & !wd[`LDM_BIT_RXZ];
						next_r.ch[wch].txz_is = r.ch[wch].txz_is & !wd[`LDM_BIT_TXZ];
					end
					`LDM_REG_IRQM2: begin
						next_r.ch[wch].rxz_im = wd[`LDM_BIT_RXZ];
						next_r.ch[wch].txz_im = wd[`LDM_BIT_TXZ];
					end
					default: ;
				endcase
			end
		end

		// hardware sets win over a clear in the same cycle
		for (int i = 0; i < LDM_NUM_CH; i++) begin
			next_r.ch[i].rxz_is = next_r.ch[i].rxz_is | rxz_set[i];
			next_r.ch[i].txz_is = next_r.ch[i].txz_is | txz_set[i];
			next_r.ch[i].lis    = next_r.ch[i].lis | lis_set[i];
		end

		// address phase capture; this slave never stretches
		if (ahb_i.hready) begin
			next_r.wr_act = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hwrite;
			next_r.rd_act = ahb_i.hsel && ahb_i.htrans[1] && !ahb_i.hwrite;
			next_r.addr   = ahb_i.haddr[11:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			r <= '0;
		else
			r <= next_r;
	end

	// ==================================================
	// read mux, from registered state only
	always_comb begin
		rd = '0;
		if (r.rd_act && r.addr[11:10] == 2'h0) begin
			if (r.addr[`LDM_GLOBAL_BIT]) begin
				unique case (r.addr[4:2])
					`LDM_GREG_MODE:   rd[`LDM_BIT_E1] = r.mode_e1;
					`LDM_GREG_CLKGEN: begin
						rd[`LDM_BIT_CLKEN]  = r.clk_en;
						rd[`LDM_BIT_CLKSEL] = r.clk_sel;
					end
					`LDM_GREG_EDGE:   rd[`LDM_BIT_EDGE] = r.edge_any;
					default:          ;
				endcase
			end else begin
				unique case (r.addr[4:2])
					`LDM_REG_DEFECT: begin
						rd[`LDM_BIT_FCC] = r.ch[wch].fcc;
						rd[`LDM_BIT_INS] = r.ch[wch].ins;
						rd[1:0]          = r.ch[wch].code;
					end
					`LDM_REG_LOSS_CFG: begin
						rd[`LDM_BIT_CRIT]      = r.ch[wch].crit;
						rd[`LDM_THR_LSB +: 3]  = r.ch[wch].thr;
					end
					`LDM_REG_RX_CFG: begin
						rd[`LDM_BIT_HOLD]  = r.ch[wch].hold;
						rd[`LDM_BIT_TXNRZ] = r.ch[wch].tx_nrz;
						rd[1:0]            = r.ch[wch].fmt;
					end
					`LDM_REG_STATUS_REG_ZERO: rd[`LDM_BIT_LOSS] = r.ch[wch].loss;
					`LDM_REG_IRQS0: rd[`LDM_BIT_LOSS] = r.ch[wch].lis;
					`LDM_REG_IRQM0: rd[`LDM_BIT_LOSS] = r.ch[wch].lim;
					`LDM_REG_IRQS2: begin
						rd[`LDM_BIT_RXZ] = r.ch[wch].rxz_is;
						rd[`LDM_BIT_TXZ] = r.ch[wch].txz_is;
					end
					`LDM_REG_IRQM2: begin
						rd[`LDM_BIT_RXZ] = r.ch[wch].rxz_im;
						rd[`LDM_BIT_TXZ] = r.ch[wch].txz_im;
					end
					default: ;
				endcase
			end
		end
	end

	// ==================================================
	// outputs
	always_comb begin
		for (int i = 0; i < LDM_NUM_CH; i++) begin
			tx_pos_o[i]               = r.ch[i].tx_pos;
			tx_neg_o[i]               = r.ch[i].tx_neg;
			rx_positive_data_out_o[i] = r.ch[i].rx_pos;
			rx_negative_data_out_o[i] = r.ch[i].rx_neg;
			rx_clock_out_o[i]         = r.ch[i].rx_clk;
			irq_vec[i] = (r.ch[i].lis && !r.ch[i].lim) || (r.ch[i].rxz_is && !r.ch[i].rxz_im)
				|| (r.ch[i].txz_is && !r.ch[i].txz_im);
		end
	end

	assign hreadyout_o            = 1'b1;
	assign hresp_o                = 1'b0;
	assign hrdata_o               = rd;
	assign int_b_o                = !(|irq_vec);
	assign derived_rate_clock_o   = r.acc[23];
	assign indication_clock_out_o = r.ind_clk;
	assign loss_frame_marker_o    = r.marker;
	assign line_signal_loss_o     = r.sdata;
	assign loss_frame_marker_oe_o = r.pins_oe;
	assign line_signal_loss_oe_o  = r.pins_oe;

	// ==================================================
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	pins_float_a: assert property (!(r.clk_en && r.clk_sel) |=> !loss_frame_marker_oe_o && !line_signal_loss_oe_o)
		else $error("indication pins driven while clock disabled");
	frame_start_a: assert property ((r.clk_en && r.clk_sel && !r.ind_clk && r.ind_div == IND_HALF - 8'h01
		&& r.slot == 5'h00) |=> loss_frame_marker_o && indication_clock_out_o && line_signal_loss_o == $past(r.ch[0].loss))
		else $error("frame marker or channel 0 slot wrong");

	for (genvar g = 0; g < LDM_NUM_CH; g++) begin : g_chk
		rx_force_a: assert property ((r.ch[g].loss && !rx_override_i[g] && r.ch[g].fmt != LDM_RX_SLICED)
			|=> !rx_positive_data_out_o[g] && !rx_negative_data_out_o[g])
			else $error("receive data not forced low during loss");
		rx_clock_a: assert property ((r.ch[g].loss && !rx_override_i[g])
			|=> rx_clock_out_o[g] == ($past(r.ch[g].hold) ? 1'b1 : $past(r.acc[23])))
			else $error("receive clock wrong during loss");
		ins_done_a: assert property ((bit_en_i && r.ch[g].ins && (tx_pos_i[g] || tx_neg_i[g]) && !r.wr_act)
			|=> !r.ch[g].ins && tx_pos_o[g] == $past(r.ch[g].last_pol) && tx_neg_o[g] == !$past(r.ch[g].last_pol))
			else $error("violation not inserted or request not cleared");
		rx_zero_a: assert property ((bit_en_i && !rx_mark_i[g]
			&& r.ch[g].rx_zero == zthr(r.ch[g].code, r.ch[g].fcc, r.mode_e1)) |=> r.ch[g].rxz_is ##1 1'b1)
			else $error("receive zero run status not set");
		tx_zero_a: assert property ((bit_en_i && !(tx_pos_i[g] || tx_neg_i[g]) && r.ch[g].tx_zero ==
			zthr(r.ch[g].tx_nrz ? LDM_AMI : r.ch[g].code, r.ch[g].fcc, r.mode_e1)) |=> r.ch[g].txz_is)
			else $error("transmit zero run status not set");
		loss_edge_a: assert property ($rose(r.ch[g].loss) |-> r.ch[g].lis
			&& $past(r.ch[g].low_cnt) + 12'h001 >= $past(nlim(r.mode_e1, r.ch[g].crit)))
			else $error("loss declared early or status not set");
		irq_out_a: assert property ((r.ch[g].rxz_is && !r.ch[g].rxz_im) |-> !int_b_o)
			else $error("interrupt not raised");
	end
endmodule : ldm_line_defect_monitor

/* ldm_line_partner.sv */
`timescale 1ns/1ps
module ldm_line_partner import ldm_pkg::*; (
	// clock and control
	input  wire logic                  clk_i,
	input  wire logic                  rst_b_i,
	input  wire logic                  marks_on_i,
	// line stimulus
	output logic                       bit_en_o,
	output logic [LDM_NUM_CH-1:0]      mark_o,
	output logic [LDM_NUM_CH-1:0][7:0] amp_o,
	output logic [LDM_NUM_CH-1:0]      tx_pos_o,
	output logic [LDM_NUM_CH-1:0]      tx_neg_o
);
	logic [1:0] phase = 2'h0;
	logic       pol   = 1'b0;
	initial begin
		bit_en_o = 1'b0;
		mark_o   = '0;
		amp_o    = '0;
		tx_pos_o = '0;
		tx_neg_o = '0;
	end
	// ==================================================
	// one interval per four clocks; a dead line has no amplitude at all
	always @(posedge clk_i) begin
		phase    <= rst_b_i ? phase + 2'h1 : 2'h0;
		bit_en_o <= rst_b_i && phase == 2'h3;
		if (phase == 2'h3) begin
			pol      <= pol ^ marks_on_i;
			mark_o   <= {LDM_NUM_CH{marks_on_i}};
			amp_o    <= marks_on_i ? {LDM_NUM_CH{8'h20}} : '0;
			tx_pos_o <= {LDM_NUM_CH{marks_on_i & pol}};
			tx_neg_o <= {LDM_NUM_CH{marks_on_i & ~pol}};
		end
	end
endmodule : ldm_line_partner

/* ldm_pkg.sv */
package ldm_pkg;
	// ==================================================
	// types
	localparam int LDM_NUM_CH = 16;

	typedef enum logic [1:0] {LDM_AMI, LDM_B8ZS, LDM_HDB3} ldm_code_type;
	typedef enum logic [1:0] {LDM_RX_SR_NRZ, LDM_RX_DR_NRZ, LDM_RX_DR_RZ, LDM_RX_SLICED} ldm_rx_fmt_type;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} ldm_ahb_req_type;

	typedef struct packed {
		logic           fcc;
		logic           ins;
		ldm_code_type   code;
		logic           crit;
		logic [2:0]     thr;
		logic           hold;
		ldm_rx_fmt_type fmt;
		logic           tx_nrz;
		logic           loss;
		logic           lis;
		logic           lim;
		logic           rxz_is;
		logic           txz_is;
		logic           rxz_im;
		logic           txz_im;
		logic [6:0]     rx_zero;
		logic [6:0]     tx_zero;
		logic           last_pol;
		logic [11:0]    low_cnt;
		logic           win_act;
		logic [7:0]     win_cnt;
		logic [7:0]     win_marks;
		logic [6:0]     win_zero;
		logic           tx_pos;
		logic           tx_neg;
		logic           rx_pos;
		logic           rx_neg;
		logic           rx_clk;
	} ldm_ch_type;

	typedef struct packed {
		ldm_ch_type [LDM_NUM_CH-1:0] ch;
		logic [23:0]                 acc;
		logic                        mode_e1;
		logic                        clk_en;
		logic                        clk_sel;
		logic                        edge_any;
		logic [7:0]                  ind_div;
		logic                        ind_clk;
		logic [4:0]                  slot;
		logic                        marker;
		logic                        sdata;
		logic                        pins_oe;
		logic                        wr_act;
		logic                        rd_act;
		logic [11:0]                 addr;
	} ldm_state_type;
endpackage : ldm_pkg

/* line_defect_monitor_test.sv */
`timescale 1ns/1ps
module line_defect_monitor_test import ldm_pkg::*; ();
	logic                       clk_i    = 1'b0;
	logic                       rst_b_i  = 1'b0;
	logic                       marks_on = 1'b0;
	logic [LDM_NUM_CH-1:0]      rx_data  = '1;
	logic [LDM_NUM_CH-1:0]      ovr      = '0;
	ldm_ahb_req_type            bus      = '0;
	ldm_ahb_req_type            ahb;
	logic                       bit_en, hready, hresp, ind_clk, marker, marker_oe, serial, serial_oe, dclk, int_b;
	logic [LDM_NUM_CH-1:0]      mark, txp, txn, tpo, tno, rdp, rdn, rck;
	logic [LDM_NUM_CH-1:0][7:0] amp;
	logic [31:0]                hrdata, rd, rd_q;
	int                         num_errors   = 0;
	int                         total_checks = 0;
	int                         cycles       = 0;
	int                         dclk_n       = 0;
	int                         viol_n       = 0;
	int                         dn;
	always #5 clk_i = ~clk_i;
	always_comb begin
		ahb        = bus;
		ahb.hready = hready;
	end
	always @(posedge clk_i) rd_q <= hrdata;
	always @(posedge dclk) dclk_n++;
	// channels 0 and 1 carry the same stream, so they differ only while a violation stands
	always @(posedge clk_i) if (tpo[0] !== tpo[1]) viol_n++;
	ldm_line_partner line (.clk_i(clk_i), .rst_b_i(rst_b_i), .marks_on_i(marks_on), .bit_en_o(bit_en), .mark_o(mark),
		.amp_o(amp), .tx_pos_o(txp), .tx_neg_o(txn));
	ldm_line_defect_monitor #(.IND_HALF(8'h02)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ahb_i(ahb),
		.hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .bit_en_i(bit_en), .rx_mark_i(mark),
		.rx_amp_i(amp), .rx_pos_i(rx_data), .rx_neg_i(rx_data), .rx_clk_i('0), .rx_override_i(ovr),
		.tx_pos_i(txp), .tx_neg_i(txn), .tx_pos_o(tpo), .tx_neg_o(tno), .rx_positive_data_out_o(rdp),
		.rx_negative_data_out_o(rdn), .rx_clock_out_o(rck), .indication_clock_out_o(ind_clk),
		.loss_frame_marker_o(marker), .loss_frame_marker_oe_o(marker_oe), .line_signal_loss_o(serial),
		.line_signal_loss_oe_o(serial_oe), .derived_rate_clock_o(dclk), .int_b_o(int_b));
	// ==================================================
	// bus and checking tasks
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_i);
		bus.hsel   <= 1'b1;
		bus.haddr  <= a;
		bus.htrans <= 2'h2;
		bus.hwrite <= wr;
		bus.hsize  <= 3'h2;
		do @(posedge clk_i); while (hready !== 1'b1);
		bus.htrans <= 2'h0;
		bus.hwdata <= d;
		do @(posedge clk_i); while (hready !== 1'b1);
		// rd_q holds what hrdata showed at the closing edge
		#1 rd = rd_q;
	endtask : xfer
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input string name);
		xfer(1'b0, a, 32'h0);
		check(name, exp, rd);
	endtask : rdchk
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test
	// the whole run needs under 2000 cycles
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			num_errors++;
			end_of_test();
		end
	end
	// ==================================================
	// tests
	initial begin
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rdchk(32'h000, 32'h0, "defect ctrl reset");
		rdchk(32'h200, 32'h0, "mode reset");
		check("int_b reset", 32'h1, {31'h0, int_b});
		check("hresp okay", 32'h0, {31'h0, hresp});
		check("marker oe off", 32'h0, {31'h0, marker_oe});
		check("serial oe off", 32'h0, {31'h0, serial_oe});
		$display("test reset done");
		xfer(1'b1, 32'h200, 32'h1);
		repeat (300) @(posedge clk_i);
		rdchk(32'h018, 32'hC, "zero run status");
		rdchk(32'h00C, 32'h1, "loss state");
		rdchk(32'h010, 32'h1, "loss irq status");
		check("int_b raised", 32'h0, {31'h0, int_b});
		check("rx data forced", 32'h0, {16'h0, rdp});
		xfer(1'b1, 32'h008, 32'h80);
		xfer(1'b1, 32'h028, 32'h3);
		@(posedge clk_i);
		#1;
		check("rx clock held", 32'h1, {31'h0, rck[0]});
		check("rx sliced kept", 32'h2, {16'h0, rdp});
		@(posedge clk_i);
		ovr <= 16'h0001;
		repeat (2) @(posedge clk_i);
		#1;
		check("override clock", 32'h0, {31'h0, rck[0]});
		check("override data", 32'h3, {16'h0, rdp});
		@(posedge clk_i);
		ovr <= '0;
		for (int i = 0; i < LDM_NUM_CH; i++) begin
			xfer(1'b1, 32'(i * 32 + 20), 32'h1);
			xfer(1'b1, 32'(i * 32 + 28), 32'hC);
		end
		check("int_b masked", 32'h1, {31'h0, int_b});
		$display("test quiet line done");
		xfer(1'b1, 32'h204, 32'hC);
		for (int i = 0; i < 40 && marker !== 1'b1; i++) begin
			@(posedge ind_clk);
			#1;
		end
		check("marker oe on", 32'h1, {31'h0, marker_oe});
		check("marker", 32'h1, {31'h0, marker});
		check("serial ch0", 32'h1, {31'h0, serial});
		@(posedge ind_clk);
		#1;
		check("marker slot1", 32'h0, {31'h0, marker});
		check("serial ch1", 32'h1, {31'h0, serial});
		repeat (15) @(posedge ind_clk);
		#1;
		check("pad slot", 32'h0, {30'h0, marker, serial});
		@(posedge ind_clk);
		#1;
		check("frame repeat", 32'h1, {31'h0, marker});
		$display("test indication done");
		xfer(1'b1, 32'h208, 32'h2);
		xfer(1'b1, 32'h010, 32'h1);
		rdchk(32'h010, 32'h0, "loss irq cleared");
		@(posedge clk_i);
		marks_on <= 1'b1;
		dn = dclk_n;
		repeat (400) @(posedge clk_i);
		check("derived clock rises", 32'h1, {31'h0, (dclk_n - dn) inside {8, 9}});
		rdchk(32'h00C, 32'h0, "loss cleared");
		rdchk(32'h010, 32'h1, "loss fall status");
		check("rx data passed", 32'h0000FFFF, {16'h0, rdp});
		check("tx marks passed", 32'h0000FFFF, {16'h0, tpo | tno});
		xfer(1'b1, 32'h000, 32'h40);
		repeat (20) @(posedge clk_i);
		rdchk(32'h000, 32'h0, "insert self clear");
		check("violation length", 32'h4, viol_n);
		$display("test recovery done");
		end_of_test();
	end
endmodule : line_defect_monitor_test
